//--- hdl/rcb_regulator_bank.sv
// Purpose: Regulator control and status register bank with serial access
// Assumes: Host keeps serial timing well below clk rate; pins are async
// Notes:   No pointer auto-increment; unmapped reads return zero
//
// Contract
// R1 - Control bit 7 turns the regulator on when one, off when zero
// R2 - Second buck bit 6 selects antiphase switching when one
// R3 - Buck bit 5 forces fixed-frequency switching when one
// R4 - Control bits 4 to 2 hold a read-write turn-on delay code
// R5 - Control bit 1 lets that regulator's faults raise the interrupt
// R6 - Control bit 0 reads the live power-good state
// R7 - Third buck uses the primary code while bank select is low
// R8 - Third buck uses the secondary code while bank select is high
// R9 - Third buck bit 6 zero lets the pushbutton enable it
// R10 - Linear bit 6 discharges the output while shut down
// R11 - Linear bit 5 selects low-power operating mode
// R12 - Linear voltage comes from a six-bit code in bits 5 to 0
// R13 - Reset output releases about 260 ms after power is requested
// R14 - Pushbutton status, interrupt and reset outputs are open-drain, low active
// R15 - Host drives hold, enable and bank select as logic inputs
// R16 - Reset timer select gives 65 ms when one, 260 ms when zero
// R17 - All bits return to defaults on power loss or undervoltage
// R18 - Voltage byte bits 7 and 6 read zero and ignore writes
// R19 - Writes never change the power-good status bit
`timescale 1ns/1ps
module rcb_regulator_bank #(
	parameter int unsigned RST_LONG_CYC  = 32'(rcb_pkg::RST_LONG_CYC),
	parameter int unsigned RST_SHORT_CYC = 32'(rcb_pkg::RST_SHORT_CYC)
) (
	// Clock and undervoltage reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Serial bus
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Host control pins
	input  wire logic        voltage_bank_select,
	input  wire logic        pushbutton_input_low,
	input  wire logic        power_hold_in,
	input  wire logic        power_enable_in,
	input  wire logic        reset_timer_short,
	// Power-good comparators, buck2 buck3 ldo4..ldo7
	input  wire logic [5:0]  power_good_in,
	// Regulator controls
	output logic [5:0]       reg_enable,
	output logic             buck2_phase,
	output logic [1:0]       buck_pwm_force,
	output logic [17:0]      turn_on_delay,
	output logic [5:0]       buck3_vcode,
	output logic [23:0]      ldo_voltage_code,
	output logic [3:0]       discharge_enable,
	output logic [3:0]       low_quiescent_select,
	// Open-drain outputs
	output logic             reset_out_low_o,
	output logic             reset_out_low_oe,
	output logic             interrupt_out_low_o,
	output logic             interrupt_out_low_oe,
	output logic             pushbutton_status_out_low_o,
	output logic             pushbutton_status_out_low_oe
);
	typedef struct packed {
		rcb_pkg::rcb_state_e                  st;
		logic [3:0]                           cnt;
		logic [7:0]                           shreg;
		logic [7:0]                           ptr;
		logic                                 rw;
		logic                                 sda_oe;
		logic                                 scl_q;
		logic                                 sda_q;
		logic [5:0][6:0]                      ctrl;
		logic [5:0][5:0]                      volt;
		logic [5:0]                           en;
		logic                                 phase;
		logic [1:0]                           pwm;
		logic [17:0]                          dly;
		logic [5:0]                           b3v;
		logic [23:0]                          lv;
		logic [3:0]                           dis;
		logic [3:0]                           liq;
		logic                                 rst_oe;
		logic                                 irq_oe;
		logic                                 pb_oe;
		logic                                 od_lvl;
	} rcb_regs_s;

	rcb_regs_s         r;
	rcb_regs_s         next_r;
	logic [11:0]       sync_q;
	logic              scl_s;
	logic              sda_s;
	logic              voltage_bank_select_s;
	logic              pb_s;
	logic              hold_s;
	logic              power_enable_in_s;
	logic [5:0]        pg_s;
	logic              scl_r;
	logic              scl_f;
	logic              start;
	logic              stop;
	logic              wr_fire;
	logic              rd_load;
	logic [7:0]        rd_byte;
	logic [5:0]        unmask;
	rcb_pkg::rcb_dec_s dec;
	rcb_rst_if         tif ();

	rcb_sync #(
		.W (12)
	) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({scl_in, sda_in, voltage_bank_select, ~pushbutton_input_low,
		         power_hold_in, power_enable_in, power_good_in}),
		.q     (sync_q)
	);

	assign {scl_s, sda_s, voltage_bank_select_s} = sync_q[11:9];
	assign pb_s    = sync_q[8]; // Inverted ahead of the flops so reset reads as released
	assign hold_s  = sync_q[7];  // R15
	assign power_enable_in_s = sync_q[6];  // R15
	assign pg_s    = sync_q[5:0];

	assign tif.run       = hold_s | power_enable_in_s;
	assign tif.short_sel = reset_timer_short; // R16

	rcb_rst_timer #(
		.LONG_CYC  (RST_LONG_CYC),
		.SHORT_CYC (RST_SHORT_CYC)
	) u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.t     (tif)
	);

	always_comb
	begin
		next_r   = r;
		scl_r    = scl_s & ~r.scl_q;
		scl_f    = ~scl_s & r.scl_q;
		start    = r.scl_q & scl_s & r.sda_q & ~sda_s;
		stop     = r.scl_q & scl_s & ~r.sda_q & sda_s;
		wr_fire  = 1'b0;
		rd_load  = 1'b0;
		dec      = rcb_pkg::rcb_decode(r.ptr);
		unmask   = '0;
		next_r.scl_q = scl_s;
		next_r.sda_q = sda_s;

		if (dec.ctrl)
			rd_byte = {r.ctrl[dec.idx], pg_s[dec.idx]}; // R6 R19
		else if (dec.volt)
			rd_byte = {2'h0, r.volt[dec.idx]}; // R18
		else
			rd_byte = 8'h00;

		case (r.st)
			rcb_pkg::ST_IDLE:
				next_r.sda_oe = 1'b0;
			rcb_pkg::ST_DEV, rcb_pkg::ST_REG, rcb_pkg::ST_WDATA:
			begin
				if (scl_r)
				begin
					next_r.shreg = {r.shreg[6:0], sda_s};
					next_r.cnt   = r.cnt + 1'b1;
				end
				else if (scl_f && r.cnt == rcb_pkg::BITS8)
				begin
					next_r.sda_oe = 1'b1;
					next_r.st     = rcb_pkg::ST_WACK;
					if (r.st == rcb_pkg::ST_DEV)
					begin
						next_r.rw = r.shreg[0];
						next_r.st = rcb_pkg::ST_AACK;
						if (r.shreg[7:1] != rcb_pkg::DEV_ADDR)
						begin
							next_r.sda_oe = 1'b0;
							next_r.st     = rcb_pkg::ST_IDLE;
						end
					end
					else if (r.st == rcb_pkg::ST_REG)
						next_r.ptr = r.shreg;
					else
						wr_fire = 1'b1;
				end
			end
			rcb_pkg::ST_AACK:
				if (scl_f)
				begin
					next_r.cnt    = '0;
					next_r.sda_oe = 1'b0;
					if (r.rw)
						rd_load = 1'b1;
					else
						next_r.st = rcb_pkg::ST_REG;
				end
			rcb_pkg::ST_WACK:
				if (scl_f)
				begin
					next_r.cnt    = '0;
					next_r.sda_oe = 1'b0;
					next_r.st     = rcb_pkg::ST_WDATA;
				end
			rcb_pkg::ST_RDATA:
				if (scl_f)
				begin
					if (r.cnt == rcb_pkg::BITS8)
					begin
						next_r.sda_oe = 1'b0;
						next_r.st     = rcb_pkg::ST_MACK;
					end
					else
					begin
						next_r.sda_oe = ~r.shreg[7];
						next_r.shreg  = {r.shreg[6:0], 1'b0};
						next_r.cnt    = r.cnt + 1'b1;
					end
				end
			rcb_pkg::ST_MACK:
				if (scl_r && sda_s)
					next_r.st = rcb_pkg::ST_IDLE;
				else if (scl_f)
					rd_load = 1'b1;
			default:
				next_r.st = rcb_pkg::ST_IDLE;
		endcase

		// Read byte goes out MSB first, open-drain
		if (rd_load)
		begin
			next_r.st     = rcb_pkg::ST_RDATA;
			next_r.shreg  = {rd_byte[6:0], 1'b0};
			next_r.sda_oe = ~rd_byte[7];
			next_r.cnt    = rcb_pkg::BIT1;
		end

		// Status bit is never stored; reserved voltage bits dropped
		if (wr_fire && dec.ctrl)
			next_r.ctrl[dec.idx] = r.shreg[7:1]; // R1 R4 R19
		if (wr_fire && dec.volt)
			next_r.volt[dec.idx] = r.shreg[5:0]; // R12 R18

		if (start)
		begin
			next_r.st     = rcb_pkg::ST_DEV;
			next_r.cnt    = '0;
			next_r.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			next_r.st     = rcb_pkg::ST_IDLE;
			next_r.sda_oe = 1'b0;
		end

		for (int i = 0; i < rcb_pkg::NCH; i++)
		begin
			next_r.en[i] = r.ctrl[i][rcb_pkg::C_ON]; // R1
			next_r.dly[i*rcb_pkg::DLY_W +: rcb_pkg::DLY_W] =
				r.ctrl[i][rcb_pkg::C_DLY +: rcb_pkg::DLY_W]; // R4
			unmask[i] = r.ctrl[i][rcb_pkg::C_UNM];
		end
		next_r.en[1] = r.ctrl[1][rcb_pkg::C_ON]
			| (~r.ctrl[1][rcb_pkg::C_B6] & pb_s); // R9
		next_r.phase  = r.ctrl[0][rcb_pkg::C_B6]; // R2
		next_r.pwm    = {r.ctrl[1][rcb_pkg::C_B5],
		                 r.ctrl[0][rcb_pkg::C_B5]}; // R3
		next_r.b3v    = voltage_bank_select_s ? r.volt[1] : r.volt[0]; // R7 R8
		for (int j = 0; j < rcb_pkg::NLDO; j++)
		begin
			next_r.lv[j*rcb_pkg::VC_W +: rcb_pkg::VC_W] =
				r.volt[j + rcb_pkg::LDO0]; // R12
			next_r.dis[j] = r.ctrl[j + rcb_pkg::LDO0][rcb_pkg::C_B6]
				& ~r.ctrl[j + rcb_pkg::LDO0][rcb_pkg::C_ON]; // R10
			next_r.liq[j] = r.ctrl[j + rcb_pkg::LDO0][rcb_pkg::C_B5]; // R11
		end
		// Fault: enabled output below its power-good threshold
		next_r.irq_oe = |(unmask & r.en & ~pg_s); // R5 R14
		next_r.rst_oe = ~tif.done; // R13 R14
		next_r.pb_oe  = pb_s; // R14
		next_r.od_lvl = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '{st: rcb_pkg::ST_IDLE, ctrl: rcb_pkg::CTRL_RST,
			       volt: rcb_pkg::VOLT_RST, rst_oe: 1'b1,
			       scl_q: 1'b1, sda_q: 1'b1, default: '0}; // R17
		else
			r <= next_r;
	end

	assign sda_out                      = r.od_lvl;
	assign sda_oe                       = r.sda_oe;
	assign reg_enable                   = r.en;
	assign buck2_phase                  = r.phase;
	assign buck_pwm_force               = r.pwm;
	assign turn_on_delay                = r.dly;
	assign buck3_vcode                  = r.b3v;
	assign ldo_voltage_code             = r.lv;
	assign discharge_enable             = r.dis;
	assign low_quiescent_select         = r.liq;
	assign reset_out_low_o              = r.od_lvl;
	assign reset_out_low_oe             = r.rst_oe;
	assign interrupt_out_low_o          = r.od_lvl;
	assign interrupt_out_low_oe         = r.irq_oe;
	assign pushbutton_status_out_low_o  = r.od_lvl;
	assign pushbutton_status_out_low_oe = r.pb_oe;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_buck2_on_write: assert property ( // R1
		wr_fire && dec.ctrl && dec.idx == 3'h0
		|-> ##2 reg_enable[0] == $past(r.shreg[7], 2))
		else $error("buck2 enable does not follow write");
	a_buck2_phase_write: assert property ( // R2
		wr_fire && dec.ctrl && dec.idx == 3'h0
		|-> ##2 buck2_phase == $past(r.shreg[6], 2))
		else $error("buck2 phase does not follow write");
	a_buck3_pwm_write: assert property ( // R3
		wr_fire && dec.ctrl && dec.idx == 3'h1
		|-> ##2 buck_pwm_force[1] == $past(r.shreg[5], 2))
		else $error("buck3 pwm does not follow write");
	a_ldo4_delay_write: assert property ( // R4
		wr_fire && dec.ctrl && dec.idx == 3'h2
		|-> ##2 turn_on_delay[8:6] == $past(r.shreg[4:2], 2))
		else $error("ldo4 delay does not follow write");
	a_irq_all_masked: assert property ( // R5
		unmask == 6'h00 |=> !interrupt_out_low_oe)
		else $error("interrupt with every fault masked");
	a_status_read_live: assert property ( // R6
		dec.ctrl |-> rd_byte[0] == pg_s[dec.idx])
		else $error("status bit not live power-good");
	a_bank_low_primary: assert property ( // R7
		!voltage_bank_select_s |=> buck3_vcode == $past(r.volt[0]))
		else $error("primary code not selected");
	a_bank_high_secondary: assert property ( // R8
		voltage_bank_select_s |=> buck3_vcode == $past(r.volt[1]))
		else $error("secondary code not selected");
	a_pushbutton_enable: assert property ( // R9
		!r.ctrl[1][rcb_pkg::C_B6] && pb_s |=> reg_enable[1])
		else $error("pushbutton did not enable buck3");
	a_discharge_off_only: assert property ( // R10
		(discharge_enable & reg_enable[5:2]) == 4'h0)
		else $error("discharge while regulator on");
	a_reserved_zero: assert property ( // R18
		dec.volt |-> rd_byte[7:6] == 2'h0)
		else $error("reserved voltage bits not zero");
	a_reset_defaults: assert property (disable iff (1'b0) // R17
		!rst_n |=> r.ctrl == rcb_pkg::CTRL_RST && r.volt == rcb_pkg::VOLT_RST)
		else $error("registers not at defaults after reset");

	c_reg_write: cover property (wr_fire && dec.ctrl);
	c_reg_read: cover property (rd_load && dec.volt);
	c_reset_release: cover property ($fell(reset_out_low_oe));
	c_fault_irq: cover property ($rose(interrupt_out_low_oe));
endmodule

//--- hdl/rcb_pkg.sv
// Purpose: Shared constants and types for the regulator register bank
// Assumes: 40 MHz core clock, byte-wide serial register access
// Notes:   Stored control bytes keep bits 7..1; bit 0 is live status
package rcb_pkg;
	localparam logic [7:0] OFS_B2_CTRL = 8'h32;
	localparam logic [7:0] OFS_B3_PRI  = 8'h40;
	localparam logic [7:0] OFS_B3_SEC  = 8'h41;
	localparam logic [7:0] OFS_B3_CTRL = 8'h42;
	localparam logic [7:0] OFS_L4_VOLT = 8'h50;
	localparam logic [7:0] OFS_L4_CTRL = 8'h51;
	localparam logic [7:0] OFS_L5_VOLT = 8'h54;
	localparam logic [7:0] OFS_L5_CTRL = 8'h55;
	localparam logic [7:0] OFS_L6_VOLT = 8'h60;
	localparam logic [7:0] OFS_L6_CTRL = 8'h61;
	localparam logic [7:0] OFS_L7_VOLT = 8'h64;
	localparam logic [7:0] OFS_L7_CTRL = 8'h65;

	localparam int NCH    = 6;
	localparam int NLDO   = 4;
	localparam int LDO0   = 2;
	localparam int VC_W   = 6;
	localparam int CT_W   = 7;
	localparam int DLY_W  = 3;
	// Positions inside the stored 7-bit control field
	localparam int C_ON   = 6;
	localparam int C_B6   = 5;
	localparam int C_B5   = 4;
	localparam int C_DLY  = 1;
	localparam int C_UNM  = 0;

	localparam logic [NCH-1:0][CT_W-1:0] CTRL_RST =
		{7'h20, 7'h20, 7'h20, 7'h26, 7'h06, 7'h06};
	localparam logic [NCH-1:0][VC_W-1:0] VOLT_RST =
		{6'h39, 6'h39, 6'h18, 6'h18, 6'h18, 6'h18};

	// Serial address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h2d;
	localparam logic [3:0] BITS8    = 4'h8;
	localparam logic [3:0] BIT1     = 4'h1;

	localparam longint unsigned CLK_HZ    = 40_000_000;
	localparam longint unsigned RST_LONG_MS  = 260;
	localparam longint unsigned RST_SHORT_MS = 65;
	localparam longint unsigned RST_LONG_CYC =
		RST_LONG_MS * CLK_HZ / 1000;
	localparam longint unsigned RST_SHORT_CYC =
		RST_SHORT_MS * CLK_HZ / 1000;
	localparam int CNT_W = 24;

	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_DEV   = 8'h02,
		ST_REG   = 8'h04,
		ST_WDATA = 8'h08,
		ST_AACK  = 8'h10,
		ST_WACK  = 8'h20,
		ST_RDATA = 8'h40,
		ST_MACK  = 8'h80
	} rcb_state_e;

	typedef struct packed {
		logic       ctrl;
		logic       volt;
		logic [2:0] idx;
	} rcb_dec_s;

	function automatic rcb_dec_s rcb_decode(input logic [7:0] a);
		rcb_dec_s d;
		d = '{ctrl: 1'b0, volt: 1'b0, idx: 3'h0};
		case (a)
			OFS_B2_CTRL: d = '{1'b1, 1'b0, 3'h0};
			OFS_B3_CTRL: d = '{1'b1, 1'b0, 3'h1};
			OFS_L4_CTRL: d = '{1'b1, 1'b0, 3'h2};
			OFS_L5_CTRL: d = '{1'b1, 1'b0, 3'h3};
			OFS_L6_CTRL: d = '{1'b1, 1'b0, 3'h4};
			OFS_L7_CTRL: d = '{1'b1, 1'b0, 3'h5};
			OFS_B3_PRI:  d = '{1'b0, 1'b1, 3'h0};
			OFS_B3_SEC:  d = '{1'b0, 1'b1, 3'h1};
			OFS_L4_VOLT: d = '{1'b0, 1'b1, 3'h2};
			OFS_L5_VOLT: d = '{1'b0, 1'b1, 3'h3};
			OFS_L6_VOLT: d = '{1'b0, 1'b1, 3'h4};
			OFS_L7_VOLT: d = '{1'b0, 1'b1, 3'h5};
			default:     d = '{ctrl: 1'b0, volt: 1'b0, idx: 3'h0};
		endcase
		return d;
	endfunction
endpackage

//--- hdl/rcb_rst_if.sv
// Purpose: Carries run, range select and expiry of the reset release timer
// Assumes: Single clock domain
// Notes:   ctl side is the bank, tmr side the counter
`timescale 1ns/1ps
interface rcb_rst_if;
	logic run;
	logic short_sel;
	logic done;
	modport ctl (output run, output short_sel, input done);
	modport tmr (input run, input short_sel, output done);
endinterface

//--- hdl/rcb_sync.sv
// Purpose: Two-flop synchroniser for pin and comparator inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module rcb_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rcb_sync_s;

	rcb_sync_s r;
	rcb_sync_s next_r;

	always_comb
	begin
		next_r    = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	assign q = r.s2;
endmodule

//--- hdl/rcb_rst_timer.sv
// Purpose: Counts the reset output release delay
// Assumes: Limits are cycle counts of clk
// Notes:   Count restarts whenever run drops
`timescale 1ns/1ps
module rcb_rst_timer #(
	parameter int unsigned LONG_CYC  = 32'(rcb_pkg::RST_LONG_CYC),
	parameter int unsigned SHORT_CYC = 32'(rcb_pkg::RST_SHORT_CYC)
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Timer control
	rcb_rst_if.tmr    t
);
	typedef struct packed {
		logic [rcb_pkg::CNT_W-1:0] cnt;
		logic                      done;
	} rcb_tmr_s;

	rcb_tmr_s                  r;
	rcb_tmr_s                  next_r;
	logic [rcb_pkg::CNT_W-1:0] last;

	always_comb
	begin
		last   = t.short_sel ? rcb_pkg::CNT_W'(SHORT_CYC - 1)
		                     : rcb_pkg::CNT_W'(LONG_CYC - 1);
		next_r = r;
		if (!t.run)
			next_r = '0;
		else if (!r.done)
		begin
			if (r.cnt >= last)
				next_r.done = 1'b1; // R13 R16
			else
				next_r.cnt = r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	assign t.done = r.done;

	a_release_delay: assert property (@(posedge clk) disable iff (!rst_n) // R13
		$rose(r.done) |-> $past(r.cnt) == last && $past(t.run))
		else $error("reset release not at programmed count");
	a_timer_range: assert property (@(posedge clk) disable iff (!rst_n) // R16
		t.run && !r.done |-> r.cnt <= (t.short_sel ?
			rcb_pkg::CNT_W'(SHORT_CYC - 1) : rcb_pkg::CNT_W'(LONG_CYC - 1)))
		else $error("timer ran past its limit");
endmodule

//--- verif/rcb_host_model.sv
// Purpose: Host model that masters the serial register bus of the bank
// Assumes: Both lines open-drain with pull-ups; each phase lasts PH clocks
// Notes:   A _drv output high pulls its line low; released lines float high
`timescale 1ns/1ps
module rcb_host_model (
	// Clock
	input  wire logic clk,
	// Bus lines
	input  wire logic sda_line,
	output logic      scl_drv,
	output logic      sda_drv
);
	localparam int PH = 8;
	logic acks_ok;

	initial
	begin
		scl_drv = 1'b0;
		sda_drv = 1'b0;
		acks_ok = 1'b1;
	end

	task automatic hold();
		repeat (PH) @(posedge clk);
		#1;
	endtask

	// Also serves as repeated start: SDA released, SCL released, then SDA falls
	task automatic start();
		sda_drv = 1'b0;
		hold();
		scl_drv = 1'b0;
		hold();
		sda_drv = 1'b1;
		hold();
		scl_drv = 1'b1;
		hold();
	endtask

	task automatic stop();
		sda_drv = 1'b1;
		hold();
		scl_drv = 1'b0;
		hold();
		sda_drv = 1'b0;
		hold();
	endtask

	// Data changes only while SCL is low and is held past the falling edge
	task automatic xfer_bit(input logic b, output logic r);
		sda_drv = ~b;
		hold();
		scl_drv = 1'b0;
		hold();
		r = sda_line;
		scl_drv = 1'b1;
		hold();
	endtask

	task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			xfer_bit(d[i], r);
			q[i] = r;
		end
		xfer_bit(last, r);
		if (last && r)
			acks_ok = 1'b0;
	endtask

	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		start();
		xfer_byte({rcb_pkg::DEV_ADDR, 1'b0}, 1'b1, q);
		xfer_byte(a, 1'b1, q);
		xfer_byte(d, 1'b1, q);
		stop();
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
		logic nack;
		start();
		xfer_byte({rcb_pkg::DEV_ADDR, 1'b0}, 1'b1, q);
		xfer_byte(a, 1'b1, q);
		start();
		xfer_byte({rcb_pkg::DEV_ADDR, 1'b1}, 1'b1, q);
		for (int i = 7; i >= 0; i--)
			xfer_bit(1'b1, q[i]);
		// Master NACK slot: the device must have let go of the line
		xfer_bit(1'b1, nack);
		if (!nack)
			acks_ok = 1'b0;
		stop();
	endtask
endmodule

//--- verif/regulator_control_register_bank_tb_top.sv
// Purpose: Self-checking bench for the regulator register bank
// Assumes: Shortened reset release counts of 40 and 10 clocks
// Notes:   Pins are driven 1 ns after the rising clock edge
`timescale 1ns/1ps
module regulator_control_register_bank_tb_top;
	logic        clk;
	logic        rst_n;
	logic        voltage_bank_select;
	logic        pushbutton_input_low;
	logic        power_hold_in;
	logic        power_enable_in;
	logic        reset_timer_short;
	logic [5:0]  power_good_in;
	logic        sda_out;
	logic        sda_oe;
	logic [5:0]  reg_enable;
	logic        buck2_phase;
	logic [1:0]  buck_pwm_force;
	logic [17:0] turn_on_delay;
	logic [5:0]  buck3_vcode;
	logic [23:0] ldo_voltage_code;
	logic [3:0]  discharge_enable;
	logic [3:0]  low_quiescent_select;
	logic        rst_o;
	logic        rst_oe;
	logic        irq_o;
	logic        irq_oe;
	logic        pb_o;
	logic        pb_oe;
	logic        scl_drv;
	logic        sda_drv;
	wire logic   sda_line;
	int          num_errors;
	int          checked;

	// Either party pulling low wins; pull-up otherwise
	assign sda_line = ~(sda_drv | (sda_oe & ~sda_out));

	rcb_host_model host (.clk(clk), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv));

	rcb_regulator_bank #(.RST_LONG_CYC(40), .RST_SHORT_CYC(10)) dut (
		.clk(clk), .rst_n(rst_n), .scl_in(~scl_drv), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe),
		.voltage_bank_select(voltage_bank_select), .pushbutton_input_low(pushbutton_input_low),
		.power_hold_in(power_hold_in), .power_enable_in(power_enable_in),
		.reset_timer_short(reset_timer_short), .power_good_in(power_good_in),
		.reg_enable(reg_enable), .buck2_phase(buck2_phase), .buck_pwm_force(buck_pwm_force),
		.turn_on_delay(turn_on_delay), .buck3_vcode(buck3_vcode),
		.ldo_voltage_code(ldo_voltage_code), .discharge_enable(discharge_enable),
		.low_quiescent_select(low_quiescent_select),
		.reset_out_low_o(rst_o), .reset_out_low_oe(rst_oe),
		.interrupt_out_low_o(irq_o), .interrupt_out_low_oe(irq_oe),
		.pushbutton_status_out_low_o(pb_o), .pushbutton_status_out_low_oe(pb_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		host.read_reg(a, q);
		check($sformatf("reg %h", a), 24'(exp), 24'(q));
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.write_reg(a, d);
		tick(4);
	endtask

	task automatic t_defaults();
		logic [7:0] adr [12] = '{8'h32, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51,
			8'h54, 8'h55, 8'h60, 8'h61, 8'h64, 8'h65};
		logic [7:0] val [12] = '{8'h0d, 8'h18, 8'h18, 8'h0c, 8'h18, 8'h4d,
			8'h18, 8'h40, 8'h39, 8'h41, 8'h39, 8'h40};
		check("enable", 24'h0, 24'(reg_enable));
		check("rst pin", 24'h2, 24'({rst_oe, rst_o}));
		check("delay", 24'h000db, 24'(turn_on_delay));
		check("ldo codes", 24'he79618, ldo_voltage_code);
		check("discharge", 24'hf, 24'(discharge_enable));
		for (int i = 0; i < 12; i++)
			check_reg(adr[i], val[i]);
		power_good_in = 6'h2a;
		tick(6);
		check_reg(8'h32, 8'h0c);
	endtask

	task automatic t_ctrl();
		power_good_in = 6'h14;
		wr(8'h32, 8'hff);
		check("on", 24'h1, 24'(reg_enable[0]));
		check("phase", 24'h1, 24'(buck2_phase));
		check("pwm", 24'h1, 24'(buck_pwm_force[0]));
		check("dly", 24'h7, 24'(turn_on_delay[2:0]));
		check_reg(8'h32, 8'hfe);
		wr(8'h32, 8'h00);
		check("off", 24'h0, 24'({reg_enable[0], buck2_phase, buck_pwm_force[0],
			turn_on_delay[2:0]}));
		wr(8'h42, 8'h20);
		check("pwm3", 24'h1, 24'(buck_pwm_force[1]));
		wr(8'h51, 8'h60);
		check("ldo4 off", 24'h3, 24'({discharge_enable[0], low_quiescent_select[0]}));
		wr(8'h51, 8'he0);
		check("ldo4 on", 24'h5, 24'({reg_enable[2], discharge_enable[0],
			low_quiescent_select[0]}));
	endtask

	task automatic t_irq();
		wr(8'h51, 8'he2);
		check("irq good", 24'h0, 24'(irq_oe));
		power_good_in = 6'h10;
		tick(6);
		check("irq fault", 24'h2, 24'({irq_oe, irq_o}));
		wr(8'h51, 8'he0);
		check("irq masked", 24'h0, 24'(irq_oe));
		wr(8'h51, 8'h00);
	endtask

	task automatic t_volt();
		wr(8'h40, 8'hff);
		wr(8'h41, 8'h05);
		check("pri", 24'h3f, 24'(buck3_vcode));
		check_reg(8'h40, 8'h3f);
		voltage_bank_select = 1'b1;
		tick(6);
		check("sec", 24'h05, 24'(buck3_vcode));
		voltage_bank_select = 1'b0;
		wr(8'h64, 8'hea);
		check("ldo7", 24'h2a, 24'(ldo_voltage_code[23:18]));
		check_reg(8'h64, 8'h2a);
		check_reg(8'h33, 8'h00);
	endtask

	task automatic t_pb();
		pushbutton_input_low = 1'b0;
		tick(6);
		check("pb on", 24'h6, 24'({reg_enable[1], pb_oe, pb_o}));
		wr(8'h42, 8'h60);
		check("pb blocked", 24'h0, 24'(reg_enable[1]));
		pushbutton_input_low = 1'b1;
		tick(6);
		check("pb off", 24'h0, 24'(pb_oe));
	endtask

	task automatic t_timer(input logic short_sel, input int lo);
		int n;
		reset_timer_short = short_sel;
		power_hold_in = 1'b1;
		n = 0;
		while (rst_oe === 1'b1 && n < 200)
		begin
			tick(1);
			n++;
		end
		check("release", 24'h1, 24'(n >= lo && n <= lo + 5));
		power_hold_in = 1'b0;
		tick(4);
		check("reassert", 24'h1, 24'(rst_oe));
	endtask

	task automatic t_uv();
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(4);
		check_reg(8'h40, 8'h18);
		check_reg(8'h32, 8'h0c);
	endtask

	task automatic summarize();
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		num_errors = 0;
		checked = 0;
		rst_n = 1'b0;
		voltage_bank_select = 1'b0;
		pushbutton_input_low = 1'b1;
		power_hold_in = 1'b0;
		power_enable_in = 1'b0;
		reset_timer_short = 1'b0;
		power_good_in = 6'h15;
		tick(3);
		rst_n = 1'b1;
		tick(4);
		t_defaults();
		t_ctrl();
		t_irq();
		t_volt();
		t_pb();
		t_timer(1'b0, 42);
		t_timer(1'b1, 12);
		t_uv();
		check("acks", 24'h1, 24'(host.acks_ok));
		summarize();
	end
endmodule
